// [verilog/flash_host_map.svh]
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// ------------------------------------------------------------
// Register map (byte offsets)
// ------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_WDATA 4'h8
`define REG_STATUS 4'hc
`define STAT_BUSY 0
`define STAT_OK 1
`define STAT_FAIL 2
`define STAT_TIMEOUT 3
`define STAT_RDATA_LSB 8

// ------------------------------------------------------------
// Flash data bits and commands
// ------------------------------------------------------------
`define BIT_TOGGLE_ONE 6
`define BIT_TIMEOUT_ERR 5
`define UNLOCK_ADDR1 17'h00555
`define UNLOCK_ADDR2 17'h002aa
`define UNLOCK_DATA1 8'haa
`define UNLOCK_DATA2 8'h55
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_RESET 8'hf0

// ------------------------------------------------------------
// Bus cycle timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define STROBE_NS 80
`define HOLD_NS 30
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [verilog/flash_host_pkg.sv]
package flash_host_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_CHIP_ERASE = 3'h2,
    OP_SECTOR_ERASE = 3'h3,
    OP_READ = 3'h4,
    OP_RESET = 3'h5
  } op_t;
  typedef enum {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} cyc_state_t;
  typedef enum {ST_IDLE, ST_SEQ, ST_RDA, ST_RDB, ST_EVAL, ST_RST} ctl_state_t;
endpackage : flash_host_pkg

// [verilog/flash_cycle.sv]
`timescale 1ns/1ns
`include "flash_host_map.svh"
module flash_cycle (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Cycle request
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  // Flash pins
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  output logic [16:0] o_addr,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n
);
  flash_host_pkg::cyc_state_t state_q;
  logic [3:0] cnt_q;
  logic write_q;
  logic [7:0] dq_meta_q;
  logic [7:0] dq_sync_q;
  wire logic strobe_last = cnt_q == 4'(`STROBE_CYC - 1);
  wire logic hold_last = cnt_q == 4'(`HOLD_CYC - 1);

  // ------------------------------------------------------------
  // Data pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    dq_meta_q <= i_dq;
    dq_sync_q <= dq_meta_q;
  end

  // ------------------------------------------------------------
  // One bus cycle: setup, strobe low, strobe high recovery
  // ------------------------------------------------------------
  // Every cycle raises chip select at its end, so each read is a
  // separate access and the device advances its toggle bits.
  assign o_busy = state_q != flash_host_pkg::CY_IDLE;
  assign o_done = state_q == flash_host_pkg::CY_HOLD && hold_last;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q <= flash_host_pkg::CY_IDLE;
      cnt_q <= 4'h0;
      write_q <= 1'b0;
      o_rdata <= 8'h00;
      o_dq <= 8'h00;
      o_dq_oe <= 1'b0;
      o_addr <= 17'h00000;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      unique case (state_q)
        flash_host_pkg::CY_IDLE: begin
          if (i_start) begin
            state_q <= flash_host_pkg::CY_SETUP;
            write_q <= i_write;
            o_addr <= i_addr;
            o_dq <= i_wdata;
            o_dq_oe <= i_write;
            o_ce_n <= 1'b0;
          end
        end
        flash_host_pkg::CY_SETUP: begin
          state_q <= flash_host_pkg::CY_STROBE;
          cnt_q <= 4'h0;
          o_oe_n <= write_q;
          o_we_n <= !write_q;
        end
        flash_host_pkg::CY_STROBE: begin
          if (strobe_last) begin
            // Sample late so the two sync stages still see settled data
            state_q <= flash_host_pkg::CY_HOLD;
            cnt_q <= 4'h0;
            if (!write_q) begin
              o_rdata <= dq_sync_q;
            end
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_ce_n <= 1'b1;
          end
        end
        flash_host_pkg::CY_HOLD: begin
          if (hold_last) begin
            state_q <= flash_host_pkg::CY_IDLE;
            o_dq_oe <= 1'b0;
          end
        end
      endcase
    end
  end

  chk_strobe_width: assert property (@(posedge i_mclk) disable iff (i_srst)
    $fell(o_we_n) |-> !o_we_n [*8] ##1 o_we_n)
    else $error("write strobe width wrong");
endmodule : flash_cycle

// [verilog/flash_host.sv]
`timescale 1ns/1ns
`include "flash_host_map.svh"
module flash_host (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Flash pins
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  output logic [16:0] o_addr,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n
);
  flash_host_pkg::ctl_state_t state_q;
  flash_host_pkg::op_t op_q;
  logic [16:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rd_a_q;
  logic [7:0] rd_b_q;
  logic [2:0] step_q;
  logic recheck_q;
  logic ok_q;
  logic fail_q;
  logic timeout_q;
  logic wait_q;
  logic wr_pend_q;
  logic [3:0] bus_addr_q;
  logic cyc_busy;
  logic cyc_done;
  logic [7:0] cyc_rdata;

  // ------------------------------------------------------------
  // Command sequence tables
  // ------------------------------------------------------------
  function automatic logic [24:0] seq_word(flash_host_pkg::op_t op,
      logic [2:0] step, logic [16:0] a, logic [7:0] d);
    logic [24:0] w;
    w = {a, `CMD_RESET};
    unique case (step)
      3'h0: w = {`UNLOCK_ADDR1, `UNLOCK_DATA1};
      3'h1: w = {`UNLOCK_ADDR2, `UNLOCK_DATA2};
      3'h2: w = {`UNLOCK_ADDR1, op == flash_host_pkg::OP_PROGRAM ?
                 `CMD_PROGRAM : `CMD_ERASE_SETUP};
      3'h3: w = op == flash_host_pkg::OP_PROGRAM ? {a, d} :
                {`UNLOCK_ADDR1, `UNLOCK_DATA1};
      3'h4: w = {`UNLOCK_ADDR2, `UNLOCK_DATA2};
      3'h5: w = op == flash_host_pkg::OP_CHIP_ERASE ?
                {`UNLOCK_ADDR1, `CMD_CHIP_ERASE} : {a, `CMD_SECTOR_ERASE};
      default: w = {a, `CMD_RESET};
    endcase
    if (op == flash_host_pkg::OP_RESET) begin
      w = {a, `CMD_RESET};
    end
    return w;
  endfunction : seq_word

  function automatic logic [2:0] seq_last(flash_host_pkg::op_t op);
    logic [2:0] n;
    n = 3'h0;
    if (op == flash_host_pkg::OP_PROGRAM) begin
      n = 3'h3;
    end else if (op == flash_host_pkg::OP_CHIP_ERASE ||
                 op == flash_host_pkg::OP_SECTOR_ERASE) begin
      n = 3'h5;
    end
    return n;
  endfunction : seq_last

  // ------------------------------------------------------------
  // Bus slave decode
  // ------------------------------------------------------------
  wire logic bus_take = i_hsel && i_hready && i_htrans[1];
  wire logic bus_wr_ctrl = wr_pend_q && bus_addr_q == `REG_CTRL;
  wire logic busy = state_q != flash_host_pkg::ST_IDLE;
  wire flash_host_pkg::op_t new_op = flash_host_pkg::op_t'(i_hwdata[2:0]);
  wire logic op_valid = new_op != flash_host_pkg::OP_NONE &&
                        i_hwdata[2:0] <= 3'h5;
  wire logic launch = bus_wr_ctrl && !busy && op_valid;
  wire logic [15:0] status_word = {rd_b_q, 4'h0, timeout_q, fail_q,
                                   ok_q, busy};
  wire logic [31:0] read_mux =
    i_haddr[3:0] == `REG_CTRL ? {29'h0, op_q} :
    i_haddr[3:0] == `REG_ADDR ? {15'h0, addr_q} :
    i_haddr[3:0] == `REG_WDATA ? {24'h0, wdata_q} :
    i_haddr[3:0] == `REG_STATUS ? {16'h0, status_word} : 32'h0;
  wire logic addr_mapped = i_haddr[31:4] == 28'h0;

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wr_pend_q <= 1'b0;
      bus_addr_q <= 4'h0;
      o_hrdata <= 32'h0;
    end else begin
      wr_pend_q <= bus_take && i_hwrite && addr_mapped;
      if (bus_take) begin
        bus_addr_q <= i_haddr[3:0];
        o_hrdata <= addr_mapped ? read_mux : 32'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Flash cycle issue
  // ------------------------------------------------------------
  wire logic want_cyc = state_q == flash_host_pkg::ST_SEQ ||
                        state_q == flash_host_pkg::ST_RDA ||
                        state_q == flash_host_pkg::ST_RDB ||
                        state_q == flash_host_pkg::ST_RST;
  wire logic cyc_start = want_cyc && !wait_q && !cyc_busy;
  wire logic cyc_write = state_q == flash_host_pkg::ST_SEQ ||
                         state_q == flash_host_pkg::ST_RST;
  wire flash_host_pkg::op_t seq_op = state_q == flash_host_pkg::ST_RST ?
                                     flash_host_pkg::OP_RESET : op_q;
  wire logic [24:0] cmd_word = seq_word(seq_op, step_q, addr_q, wdata_q);
  // Reads always go to the target so polling stays in its sector
  wire logic [16:0] cyc_addr = cyc_write ? cmd_word[24:8] : addr_q;
  wire logic toggling = rd_a_q[`BIT_TOGGLE_ONE] ^
                        rd_b_q[`BIT_TOGGLE_ONE];

  flash_cycle u_cycle (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_start(cyc_start),
    .i_write(cyc_write),
    .i_addr(cyc_addr),
    .i_wdata(cmd_word[7:0]),
    .o_busy(cyc_busy),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .i_dq(i_dq),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe),
    .o_addr(o_addr),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n)
  );

  // ------------------------------------------------------------
  // Registers written by software
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      addr_q <= 17'h0;
      wdata_q <= 8'h0;
    end else if (wr_pend_q && !busy) begin
      if (bus_addr_q == `REG_ADDR) begin
        addr_q <= i_hwdata[16:0];
      end
      if (bus_addr_q == `REG_WDATA) begin
        wdata_q <= i_hwdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q <= flash_host_pkg::ST_IDLE;
      op_q <= flash_host_pkg::OP_NONE;
      step_q <= 3'h0;
      wait_q <= 1'b0;
      recheck_q <= 1'b0;
      ok_q <= 1'b0;
      fail_q <= 1'b0;
      timeout_q <= 1'b0;
      rd_a_q <= 8'h0;
      rd_b_q <= 8'h0;
    end else begin
      if (cyc_start) begin
        wait_q <= 1'b1;
      end else if (cyc_done) begin
        wait_q <= 1'b0;
      end
      unique case (state_q)
        flash_host_pkg::ST_IDLE: begin
          if (launch) begin
            op_q <= new_op;
            step_q <= 3'h0;
            recheck_q <= 1'b0;
            ok_q <= 1'b0;
            fail_q <= 1'b0;
            timeout_q <= 1'b0;
            state_q <= new_op == flash_host_pkg::OP_READ ?
                       flash_host_pkg::ST_RDA : flash_host_pkg::ST_SEQ;
          end
        end
        flash_host_pkg::ST_SEQ: begin
          if (cyc_done) begin
            step_q <= step_q + 3'h1;
            if (step_q == seq_last(op_q)) begin
              // Status is valid only after the final command strobe
              state_q <= op_q == flash_host_pkg::OP_RESET ?
                         flash_host_pkg::ST_IDLE :
                         flash_host_pkg::ST_RDA;
              ok_q <= op_q == flash_host_pkg::OP_RESET;
            end
          end
        end
        flash_host_pkg::ST_RDA: begin
          if (cyc_done) begin
            rd_a_q <= cyc_rdata;
            rd_b_q <= cyc_rdata;
            ok_q <= op_q == flash_host_pkg::OP_READ;
            state_q <= op_q == flash_host_pkg::OP_READ ?
                       flash_host_pkg::ST_IDLE : flash_host_pkg::ST_RDB;
          end
        end
        flash_host_pkg::ST_RDB: begin
          if (cyc_done) begin
            rd_b_q <= cyc_rdata;
            state_q <= flash_host_pkg::ST_EVAL;
          end
        end
        flash_host_pkg::ST_EVAL: begin
          if (!toggling) begin
            ok_q <= 1'b1;
            state_q <= flash_host_pkg::ST_IDLE;
          end else if (recheck_q) begin
            state_q <= flash_host_pkg::ST_RST;
            step_q <= 3'h0;
          end else begin
            // A timeout flag may race completion, so read another pair
            recheck_q <= rd_b_q[`BIT_TIMEOUT_ERR];
            timeout_q <= rd_b_q[`BIT_TIMEOUT_ERR];
            state_q <= flash_host_pkg::ST_RDA;
          end
        end
        flash_host_pkg::ST_RST: begin
          if (cyc_done) begin
            fail_q <= 1'b1;
            state_q <= flash_host_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_setup_after_unlock: assert property (@(posedge i_mclk)
    disable iff (i_srst)
    cyc_start && cyc_write && cmd_word[7:0] == `CMD_PROGRAM &&
    step_q != seq_last(op_q) && state_q == flash_host_pkg::ST_SEQ |->
    step_q == 3'h2 && cyc_addr == `UNLOCK_ADDR1)
    else $error("program setup out of place");
  chk_poll_address: assert property (@(posedge i_mclk) disable iff (i_srst)
    cyc_start && !cyc_write |-> ##1 o_addr == addr_q)
    else $error("poll read not at target address");
  chk_two_reads: assert property (@(posedge i_mclk) disable iff (i_srst)
    state_q == flash_host_pkg::ST_EVAL |->
    $past(state_q) == flash_host_pkg::ST_RDB)
    else $error("decision without second read");
  chk_ok_stable: assert property (@(posedge i_mclk) disable iff (i_srst)
    state_q == flash_host_pkg::ST_EVAL && !toggling |=>
    ok_q && !busy)
    else $error("stopped toggle not reported done");
  chk_recheck_first: assert property (@(posedge i_mclk) disable iff (i_srst)
    state_q == flash_host_pkg::ST_EVAL && toggling && !recheck_q &&
    rd_b_q[`BIT_TIMEOUT_ERR] |=> recheck_q &&
    state_q == flash_host_pkg::ST_RDA)
    else $error("timeout seen without recheck");
  chk_fail_resets: assert property (@(posedge i_mclk) disable iff (i_srst)
    state_q == flash_host_pkg::ST_EVAL && toggling && recheck_q |->
    ##[1:3] cyc_start && cmd_word[7:0] == `CMD_RESET)
    else $error("failure not followed by reset write");
  chk_fail_after_reset: assert property (@(posedge i_mclk)
    disable iff (i_srst)
    $rose(fail_q) |-> $past(state_q) == flash_host_pkg::ST_RST &&
    $past(cyc_done))
    else $error("failure flagged before reset write");
  chk_restart_clean: assert property (@(posedge i_mclk) disable iff (i_srst)
    launch |=> !recheck_q && !timeout_q && busy)
    else $error("monitoring did not restart clean");
endmodule : flash_host

// [sim/flash_dev_model.sv]
`timescale 1ns/1ns
module flash_dev_model #(
  parameter int BUSY_READS = 5,
  parameter int ACC_NS = 45,
  parameter logic [7:0] PROT_MASK = 8'h00
) (
  // Erase suspend request from the bench
  input wire logic i_suspend,
  // Strobes and address
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [16:0] i_addr,
  // Data pins
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe
);
  // ----------------------------------------------------------
  // Array and status state
  // ----------------------------------------------------------
  logic [7:0] mem [0:131071];
  logic [7:0] pdata;
  logic [7:0] last_wr;
  logic [2:0] step;
  logic [1:0] mode;
  logic [2:0] esec;
  logic chip, tog1, tog2, err, fail;
  logic rd_en, rd_ok;
  logic in_esec, susp, we_low;
  int left;
  int k;

  // Protected sectors start with a byte that an erase would change
  initial begin
    for (k = 0; k < 131072; k++)
      mem[k] = PROT_MASK[k[16:14]] ? 8'h5a : 8'hff;
    {step, mode, esec, chip, tog1, tog2, err, fail} = '0;
    we_low = 1'b0;
    last_wr = 8'h00;
    pdata = 8'h00;
    left = 0;
  end

  // Data only after the access time, so an early host sample is caught
  assign rd_en = !i_ce_n && !i_oe_n;
  assign #(ACC_NS) rd_ok = rd_en;
  assign o_dq_oe = rd_en && rd_ok;
  assign in_esec = chip || i_addr[16:14] == esec;
  assign susp = i_suspend && mode == 2'h2 && !chip;
  // Suspended erase: other sectors read array data, erased ones status
  assign o_dq = (mode == 2'h0 || (susp && !in_esec)) ? mem[i_addr] :
    (mode == 2'h1) ? {~pdata[7], tog1, err, 5'h00} :
    susp ? {1'h1, tog1, err, 1'h0, tog2, 3'h0} :
    {1'h0, tog1, err, !chip, tog2, 3'h0};

  // ----------------------------------------------------------
  // Command decode on the rising write strobe
  // ----------------------------------------------------------
  // Only a real falling strobe arms a write; the step out of X at reset
  // is no write
  always @(negedge i_we_n) we_low = 1'b1;

  always @(posedge i_we_n) if (we_low) begin
    we_low = 1'b0;
    last_wr = i_dq;
    if (i_dq == 8'hf0 && (mode == 2'h0 || fail)) begin
      {mode, fail, err, step} = '0;
    end else if (mode != 2'h0) begin
      step = 3'h0;
    end else begin
      case (step)
        3'h0, 3'h4: step = (i_addr == 17'h00555 && i_dq == 8'haa) ?
          step + 3'h1 : 3'h0;
        3'h1, 3'h5: step = (i_addr == 17'h002aa && i_dq == 8'h55) ?
          step + 3'h1 : 3'h0;
        3'h2: step = (i_dq == 8'ha0) ? 3'h3 : (i_dq == 8'h80) ? 3'h4 : 3'h0;
        3'h3: begin
          pdata = i_dq;
          fail = !PROT_MASK[i_addr[16:14]] && |(i_dq & ~mem[i_addr]);
          // Protected target: toggles for a few reads, data untouched
          if (!PROT_MASK[i_addr[16:14]])
            mem[i_addr] = mem[i_addr] & i_dq;
          mode = 2'h1;
          left = BUSY_READS;
          step = 3'h0;
        end
        3'h6: begin
          chip = (i_dq == 8'h10);
          esec = i_addr[16:14];
          if (chip || i_dq == 8'h30) begin
            for (k = 0; k < 131072; k++)
              if ((chip || k[16:14] == esec) && !PROT_MASK[k[16:14]])
                mem[k] = 8'hff;
            mode = 2'h2;
            left = BUSY_READS;
          end
          step = 3'h0;
        end
        default: step = 3'h0;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Each read access while busy flips a toggle bit, except suspended reads outside the erased sectors
  // ----------------------------------------------------------
  // While suspended only the erased sectors show toggling on bit three
  always @(negedge i_oe_n) begin
    if (!i_ce_n && susp) begin
      if (in_esec) tog2 = ~tog2;
    end else if (!i_ce_n && mode != 2'h0) begin
      tog1 = ~tog1;
      if (mode == 2'h2 && in_esec) tog2 = ~tog2;
      left = left - 1;
      // A failed operation keeps toggling until the reset command
      if (left <= 0 && fail) err = 1'h1;
      else if (left <= 0) mode = 2'h0;
    end
  end
endmodule : flash_dev_model

// [sim/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  logic i_mclk = 1'h0;
  logic i_srst = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic suspend = 1'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [7:0] host_dq, dev_dq, dq_bus;
  logic [7:0] dq_last = 8'h00;
  logic host_oe, dev_oe, ce_n, oe_n, we_n;
  logic [16:0] faddr;
  int err_total = 0;
  int n_checks = 0;

  always #5 i_mclk = ~i_mclk;

  // Undriven data pins show the inverse of the last driven value
  assign dq_bus = host_oe ? host_dq : dev_oe ? dev_dq : ~dq_last;
  always @(posedge i_mclk) if (host_oe || dev_oe) dq_last <= dq_bus;

  flash_host flash_host_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_dq(dq_bus), .o_dq(host_dq),
    .o_dq_oe(host_oe), .o_addr(faddr), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_we_n(we_n)
  );

  flash_dev_model #(.BUSY_READS(5), .ACC_NS(55), .PROT_MASK(8'h80))
    flash_dev_model_inst (
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(faddr),
    .i_suspend(suspend), .i_dq(dq_bus), .o_dq(dev_dq), .o_dq_oe(dev_oe)
  );

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_mclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge i_mclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_mclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : ahb

  task automatic run_op(input logic [2:0] op, input logic [16:0] a,
                        input logic [7:0] d, output logic [31:0] st);
    int n = 0;
    ahb(1'h1, 32'h4, {15'h0, a}, st);
    ahb(1'h1, 32'h8, {24'h0, d}, st);
    ahb(1'h1, 32'h0, {29'h0, op}, st);
    ahb(1'h0, 32'hc, 32'h0, st);
    if (op != 3'h5) check(st & 32'h1, 32'h1);
    while (st[0] !== 1'h0 && n < 2000) begin
      ahb(1'h0, 32'hc, 32'h0, st);
      n++;
    end
    // A poll that runs out of tries ends still busy and counts here
    check(st & 32'h1, 32'h0);
  endtask : run_op

  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic reset_state;
    logic [31:0] st;
    ahb(1'h0, 32'hc, 32'h0, st);
    check(st, 32'h0);
    ahb(1'h0, 32'h10, 32'h0, st);
    check(st, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // An undefined operation code is ignored
    ahb(1'h1, 32'h0, 32'h7, st);
    ahb(1'h0, 32'h0, 32'h0, st);
    check(st, 32'h0);
    ahb(1'h0, 32'hc, 32'h0, st);
    check(st, 32'h0);
  endtask : reset_state

  task automatic program_ok;
    logic [31:0] st;
    run_op(3'h1, 17'h04123, 8'h5a, st);
    check(st & 32'hf, 32'h2);
    check((st >> 8) & 32'hff, 32'h5a);
    check({24'h0, flash_dev_model_inst.mem[17'h04123]}, 32'h5a);
    run_op(3'h4, 17'h04123, 8'h00, st);
    check((st >> 8) & 32'hff, 32'h5a);
    ahb(1'h0, 32'h0, 32'h0, st);
    check(st & 32'h7, 32'h4);
  endtask : program_ok

  task automatic program_fail;
    logic [31:0] st;
    // Setting a cleared bit can only time out
    run_op(3'h1, 17'h04123, 8'hff, st);
    check(st & 32'hf, 32'hc);
    check({24'h0, flash_dev_model_inst.last_wr}, 32'hf0);
    check({30'h0, flash_dev_model_inst.mode}, 32'h0);
  endtask : program_fail

  task automatic erase_ops;
    logic [31:0] st;
    run_op(3'h1, 17'h08000, 8'h00, st);
    run_op(3'h3, 17'h04000, 8'h00, st);
    check(st & 32'hf, 32'h2);
    check((st >> 8) & 32'h80, 32'h80);
    check({24'h0, flash_dev_model_inst.mem[17'h04123]}, 32'hff);
    check({24'h0, flash_dev_model_inst.mem[17'h08000]}, 32'h00);
    run_op(3'h2, 17'h00000, 8'h00, st);
    check(st & 32'hf, 32'h2);
    check({24'h0, flash_dev_model_inst.mem[17'h08000]}, 32'hff);
    run_op(3'h5, 17'h00100, 8'h00, st);
    check({24'h0, flash_dev_model_inst.last_wr}, 32'hf0);
  endtask : erase_ops

  task automatic protect_ops;
    logic [31:0] st;
    // The model protects sector 7 and preloads it with 5a
    run_op(3'h1, 17'h1c010, 8'h00, st);
    check(st & 32'hf, 32'h2);
    check({24'h0, flash_dev_model_inst.mem[17'h1c010]}, 32'h5a);
    run_op(3'h3, 17'h1c000, 8'h00, st);
    check(st & 32'hf, 32'h2);
    check((st >> 8) & 32'hff, 32'h5a);
    check({24'h0, flash_dev_model_inst.mem[17'h1c010]}, 32'h5a);
  endtask : protect_ops

  task automatic suspend_ops;
    logic [31:0] st;
    suspend <= 1'h1;
    // A steady toggle bit lets the first pair report done
    run_op(3'h3, 17'h08000, 8'h00, st);
    check(st & 32'hf, 32'h2);
    check((st >> 8) & 32'ha0, 32'h80);
    run_op(3'h4, 17'h04000, 8'h00, st);
    check((st >> 8) & 32'hff, 32'hff);
    suspend <= 1'h0;
    // Resumed erase ignores the new sequence and runs to completion
    run_op(3'h3, 17'h08000, 8'h00, st);
    check(st & 32'hf, 32'h2);
    check((st >> 8) & 32'hff, 32'hff);
  endtask : suspend_ops

  initial begin
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'h0;
    reset_state();
    program_ok();
    program_fail();
    erase_ops();
    protect_ops();
    suspend_ops();
    results();
  end

  // A hang is cut short well past the expected few thousand cycles
  initial begin
    #400000;
    err_total++;
    results();
  end
endmodule : tb_top
